/* src/lcem_pkg.sv */
package lcem_pkg;

	// ************************************************************
	// instruction word layout
	// ************************************************************
	localparam int OP_W = 5;
	localparam int ARG_W = 8;
	localparam int IMM_W = 16;

	// ************************************************************
	// element banks and operand address map
	// ************************************************************
	localparam int NUM_X = 16;
	localparam int NUM_R = 64;
	localparam int NUM_C = 8;
	localparam int NUM_T = 8;
	localparam int R_IW = 6;
	localparam int C_IW = 3;
	localparam int T_IW = 3;
	localparam int X_IW = 4;
	localparam logic [ARG_W-1:0] BASE_X = 8'h00;
	localparam logic [ARG_W-1:0] BASE_R = 8'h20;
	localparam logic [ARG_W-1:0] BASE_C = 8'h60;
	localparam logic [ARG_W-1:0] BASE_T = 8'h70;

	// ************************************************************
	// nesting of gated regions
	// ************************************************************
	localparam int NEST = 8;
	localparam int NEST_W = 3;

	// ************************************************************
	// reset values and opcodes
	// ************************************************************
	localparam logic [IMM_W-1:0] VAL_ZERO = 16'h0000;
	localparam logic [IMM_W-1:0] VAL_ONE = 16'h0001;
	localparam logic [OP_W-1:0] OP_NOP = 5'h00;
	localparam logic [OP_W-1:0] OP_LOAD = 5'h01;
	localparam logic [OP_W-1:0] OP_SERIES = 5'h02;
	localparam logic [OP_W-1:0] OP_PARALLEL = 5'h03;
	localparam logic [OP_W-1:0] OP_DRIVE = 5'h04;
	localparam logic [OP_W-1:0] OP_LATCH = 5'h05;
	localparam logic [OP_W-1:0] OP_CLEAR = 5'h06;
	localparam logic [OP_W-1:0] OP_COUNT_UP = 5'h07;
	localparam logic [OP_W-1:0] OP_TIMER = 5'h08;
	localparam logic [OP_W-1:0] OP_GATE_BEGIN = 5'h09;
	localparam logic [OP_W-1:0] OP_GATE_END = 5'h0A;
	localparam logic [OP_W-1:0] OP_LOAD_RISE = 5'h0B;
	localparam logic [OP_W-1:0] OP_LOAD_FALL = 5'h0C;
	localparam logic [OP_W-1:0] OP_SERIES_RISE = 5'h0D;
	localparam logic [OP_W-1:0] OP_SERIES_FALL = 5'h0E;
	localparam logic [OP_W-1:0] OP_PAR_RISE = 5'h0F;
	localparam logic [OP_W-1:0] OP_PAR_FALL = 5'h10;
	localparam logic [OP_W-1:0] OP_PROG_END = 5'h11;
	localparam logic [OP_W-1:0] OP_APPLY = 5'h12;

endpackage

/* src/lcem_engine.sv */
// What this block does
// RULE_01 - rising count input adds one, energises coil
// RULE_02 - count equal to set closes contact
// RULE_03 - reached counter ignores further pulses
// RULE_04 - program restarts counter only via clear
// RULE_05 - enabled region executes its instructions normally
// RULE_06 - disabled region zeroes timers, coil and contact
// RULE_07 - disabled region drops counter coil, holds count
// RULE_08 - disabled region drops outputs, blocks applications
// RULE_09 - disabled region keeps latched elements unchanged
// RULE_10 - program closes region, no contact before end
// RULE_11 - eight nesting levels, each enable tracked separately
// RULE_12 - rising load stores off-to-on transition
// RULE_13 - falling load stores on-to-off transition
// RULE_14 - contact on at power-up rises first scan
// RULE_15 - rising series ands transition into result
// RULE_16 - falling series ands transition into result
// RULE_17 - rising parallel ors transition into result
// RULE_18 - falling parallel ors transition into result
// RULE_19 - scan runs from zero to end, repeats
// RULE_20 - program must finish with an end instruction
// RULE_21 - clear zeroes counter, drops coil and contact
// RULE_22 - one history bit per edge instruction
module lcem_engine #(
	parameter int PC_W = 8
) (
	input wire logic clk_in,
	input wire logic rstn_in,
	input wire logic [lcem_pkg::NUM_X-1:0] contact_pins_in,
	input wire logic [lcem_pkg::OP_W-1:0] instr_op_in,
	input wire logic [lcem_pkg::ARG_W-1:0] instr_arg_in,
	input wire logic [lcem_pkg::IMM_W-1:0] instr_imm_in,
	output logic [PC_W-1:0] pc_out,
	output logic [lcem_pkg::NUM_R-1:0] relay_out,
	output logic [lcem_pkg::NUM_C-1:0] cnt_contact_out,
	output logic [lcem_pkg::NUM_T-1:0] tmr_contact_out,
	output logic region_gate_out,
	output logic apply_fire_out,
	output logic scan_done_out
);
	import lcem_pkg::*;

	// ************************************************************
	// parameter check
	// ************************************************************
	generate
		if (PC_W < 2 || PC_W > 12)
		begin : g_bad_pc
			$error("PC_W must lie between 2 and 12");
		end
	endgenerate

	// ************************************************************
	// state
	// ************************************************************
	logic [NUM_X-1:0] x_meta;
	logic [NUM_X-1:0] x_sync;
	logic [PC_W-1:0] pc, next_pc;
	logic acc, next_acc;
	logic [NUM_R-1:0] relay, next_relay;
	logic [IMM_W-1:0] cnt_val [NUM_C];
	logic [IMM_W-1:0] next_cnt_val [NUM_C];
	logic [IMM_W-1:0] cnt_set [NUM_C];
	logic [IMM_W-1:0] next_cnt_set [NUM_C];
	logic [NUM_C-1:0] cnt_coil, next_cnt_coil;
	logic [IMM_W-1:0] tmr_val [NUM_T];
	logic [IMM_W-1:0] next_tmr_val [NUM_T];
	logic [IMM_W-1:0] tmr_set [NUM_T];
	logic [IMM_W-1:0] next_tmr_set [NUM_T];
	logic [NUM_T-1:0] tmr_coil, next_tmr_coil;
	logic [NEST-1:0] mc_active, next_mc_active;
	logic [NEST-1:0] mc_cond, next_mc_cond;
	logic [2**PC_W-1:0] edge_hist, next_edge_hist;
	logic scan_done, next_scan_done;
	logic gate;
	logic opnd;
	logic rise;
	logic fall;
	logic is_r, is_c, is_t;
	logic [R_IW-1:0] ridx;
	logic [C_IW-1:0] cidx;
	logic [T_IW-1:0] tidx;
	logic [NEST_W-1:0] nest;
	logic [NUM_C-1:0] cnt_hit;
	logic cnt_step;

	// ************************************************************
	// operand decode helpers
	// ************************************************************
	function automatic logic in_bank(input logic [ARG_W-1:0] a, input logic [ARG_W-1:0] base,
		input int n);
		in_bank = (a >= base) && (int'(a) < int'(base) + n);
	endfunction

	function automatic logic [ARG_W-1:0] bank_off(input logic [ARG_W-1:0] a,
		input logic [ARG_W-1:0] base);
		bank_off = a - base;
	endfunction

	// pin contacts pass two flops before use
	always_ff @(posedge clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			x_meta <= '0;
			x_sync <= '0;
		end
		else
		begin
			x_meta <= contact_pins_in;
			x_sync <= x_meta;
		end
	end

	// ************************************************************
	// operand fetch and edge detection
	// ************************************************************
	// contact state of the selected element
	always_comb
	begin
		is_r = in_bank(instr_arg_in, BASE_R, NUM_R);
		is_c = in_bank(instr_arg_in, BASE_C, NUM_C);
		is_t = in_bank(instr_arg_in, BASE_T, NUM_T);
		ridx = R_IW'(bank_off(instr_arg_in, BASE_R));
		cidx = C_IW'(bank_off(instr_arg_in, BASE_C));
		tidx = T_IW'(bank_off(instr_arg_in, BASE_T));
		nest = instr_arg_in[NEST_W-1:0];
		opnd = 1'b0;
		if (in_bank(instr_arg_in, BASE_X, NUM_X))
			opnd = x_sync[X_IW'(bank_off(instr_arg_in, BASE_X))];
		else if (is_r)
			opnd = relay[ridx];
		else if (is_c)
			opnd = cnt_hit[cidx];
		else if (is_t)
			opnd = tmr_contact_out[tidx];
		gate = &(mc_cond | ~mc_active); // RULE_05 RULE_11
		rise = opnd & ~edge_hist[pc]; // RULE_22 RULE_14
		fall = ~opnd & edge_hist[pc]; // RULE_22
		cnt_step = (instr_op_in == OP_COUNT_UP) && is_c && gate && acc && !cnt_coil[cidx]
			&& (cnt_val[cidx] != instr_imm_in);
	end

	// contacts derived from counter and timer state
	generate
		for (genvar i = 0; i < NUM_C; i++)
		begin : g_cnt
			assign cnt_hit[i] = (cnt_val[i] == cnt_set[i]); // RULE_02
		end
		for (genvar j = 0; j < NUM_T; j++)
		begin : g_tmr
			assign tmr_contact_out[j] = tmr_coil[j] && (tmr_val[j] >= tmr_set[j]);
		end
	endgenerate
	assign cnt_contact_out = cnt_hit;

	// ************************************************************
	// instruction execution
	// ************************************************************
	// next values of all engine state except the pin synchroniser flops
	always_comb
	begin
		next_pc = PC_W'(pc + 1'b1);
		next_acc = acc;
		next_relay = relay;
		next_cnt_val = cnt_val;
		next_cnt_set = cnt_set;
		next_cnt_coil = cnt_coil;
		next_tmr_val = tmr_val;
		next_tmr_set = tmr_set;
		next_tmr_coil = tmr_coil;
		next_mc_active = mc_active;
		next_mc_cond = mc_cond;
		next_edge_hist = edge_hist;
		next_scan_done = 1'b0;
		apply_fire_out = 1'b0;
		case (instr_op_in)
			OP_LOAD: next_acc = opnd;
			OP_SERIES: next_acc = acc & opnd;
			OP_PARALLEL: next_acc = acc | opnd;
			OP_LOAD_RISE:
			begin
				next_acc = rise; // RULE_12
				next_edge_hist[pc] = opnd;
			end
			OP_LOAD_FALL:
			begin
				next_acc = fall; // RULE_13
				next_edge_hist[pc] = opnd;
			end
			OP_SERIES_RISE:
			begin
				next_acc = acc & rise; // RULE_15
				next_edge_hist[pc] = opnd;
			end
			OP_SERIES_FALL:
			begin
				next_acc = acc & fall; // RULE_16
				next_edge_hist[pc] = opnd;
			end
			OP_PAR_RISE:
			begin
				next_acc = acc | rise; // RULE_17
				next_edge_hist[pc] = opnd;
			end
			OP_PAR_FALL:
			begin
				next_acc = acc | fall; // RULE_18
				next_edge_hist[pc] = opnd;
			end
			OP_DRIVE:
			begin
				if (is_r)
					next_relay[ridx] = acc & gate; // RULE_08
			end
			OP_LATCH:
			begin
				if (is_r && gate && acc) // RULE_09
					next_relay[ridx] = 1'b1;
			end
			OP_CLEAR:
			begin
				if (gate && acc) // RULE_09
				begin
					if (is_r)
						next_relay[ridx] = 1'b0;
					if (is_c)
					begin
						next_cnt_val[cidx] = VAL_ZERO; // RULE_21 RULE_04
						next_cnt_coil[cidx] = 1'b0;
					end
					if (is_t)
					begin
						next_tmr_val[tidx] = VAL_ZERO;
						next_tmr_coil[tidx] = 1'b0;
					end
				end
			end
			OP_COUNT_UP:
			begin
				if (is_c)
				begin
					next_cnt_set[cidx] = instr_imm_in;
					if (!gate)
						next_cnt_coil[cidx] = 1'b0; // RULE_07
					else
					begin
						next_cnt_coil[cidx] = acc; // RULE_01
						if (cnt_step) // RULE_03
							next_cnt_val[cidx] = cnt_val[cidx] + VAL_ONE; // RULE_01
					end
				end
			end
			OP_TIMER:
			begin
				if (is_t)
				begin
					next_tmr_set[tidx] = instr_imm_in;
					if (gate && acc)
					begin
						next_tmr_coil[tidx] = 1'b1;
						if (tmr_val[tidx] < instr_imm_in)
							next_tmr_val[tidx] = tmr_val[tidx] + VAL_ONE;
					end
					else
					begin
						next_tmr_val[tidx] = VAL_ZERO; // RULE_06
						next_tmr_coil[tidx] = 1'b0; // RULE_06
					end
				end
			end
			OP_GATE_BEGIN:
			begin
				next_mc_active[nest] = 1'b1; // RULE_11
				next_mc_cond[nest] = acc;
			end
			OP_GATE_END:
			begin
				// closing a level also closes any deeper one
				for (int k = 0; k < NEST; k++)
					if (k >= int'(nest))
						next_mc_active[k] = 1'b0; // RULE_11 RULE_10
			end
			OP_APPLY: apply_fire_out = gate & acc; // RULE_08
			OP_PROG_END:
			begin
				next_pc = '0; // RULE_19 RULE_20
				next_mc_active = '0;
				next_scan_done = 1'b1;
			end
			default: next_acc = acc;
		endcase
	end

	// registers of the engine
	always_ff @(posedge clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			pc <= '0;
			acc <= 1'b0;
			relay <= '0;
			cnt_coil <= '0;
			tmr_coil <= '0;
			mc_active <= '0;
			mc_cond <= '0;
			edge_hist <= '0; // RULE_14
			scan_done <= 1'b0;
			for (int i = 0; i < NUM_C; i++)
			begin
				cnt_val[i] <= VAL_ZERO;
				cnt_set[i] <= VAL_ZERO;
			end
			for (int j = 0; j < NUM_T; j++)
			begin
				tmr_val[j] <= VAL_ZERO;
				tmr_set[j] <= VAL_ZERO;
			end
		end
		else
		begin
			pc <= next_pc;
			acc <= next_acc;
			relay <= next_relay;
			cnt_val <= next_cnt_val;
			cnt_set <= next_cnt_set;
			cnt_coil <= next_cnt_coil;
			tmr_val <= next_tmr_val;
			tmr_set <= next_tmr_set;
			tmr_coil <= next_tmr_coil;
			mc_active <= next_mc_active;
			mc_cond <= next_mc_cond;
			edge_hist <= next_edge_hist;
			scan_done <= next_scan_done;
		end
	end

	assign pc_out = pc;
	assign relay_out = relay;
	assign region_gate_out = gate;
	assign scan_done_out = scan_done;

	// ************************************************************
	// checks
	// ************************************************************
	property p_count_step;
		@(posedge clk_in) disable iff (!rstn_in)
		cnt_step |=> cnt_val[$past(cidx)] == IMM_W'($past(cnt_val[cidx]) + VAL_ONE);
	endproperty
	a_count_step: assert property (p_count_step) else $error("count did not step"); // RULE_01

	property p_count_hit;
		@(posedge clk_in) disable iff (!rstn_in)
		(cnt_step && IMM_W'(cnt_val[cidx] + VAL_ONE) == instr_imm_in)
		|=> cnt_contact_out[$past(cidx)];
	endproperty
	a_count_hit: assert property (p_count_hit) else $error("contact not closed"); // RULE_02

	property p_count_hold;
		@(posedge clk_in) disable iff (!rstn_in)
		(instr_op_in == OP_COUNT_UP && is_c && cnt_val[cidx] == instr_imm_in)
		|=> cnt_val[$past(cidx)] == $past(cnt_val[cidx]) && cnt_contact_out[$past(cidx)];
	endproperty
	a_count_hold: assert property (p_count_hold) else $error("reached count moved"); // RULE_03

	property p_count_gated;
		@(posedge clk_in) disable iff (!rstn_in)
		(instr_op_in == OP_COUNT_UP && is_c && !gate)
		|=> !cnt_coil[$past(cidx)] && cnt_val[$past(cidx)] == $past(cnt_val[cidx]);
	endproperty
	a_count_gated: assert property (p_count_gated) else $error("gated counter wrong"); // RULE_07

	property p_timer_gated;
		@(posedge clk_in) disable iff (!rstn_in)
		(instr_op_in == OP_TIMER && is_t && !gate)
		|=> tmr_val[$past(tidx)] == VAL_ZERO && !tmr_contact_out[$past(tidx)];
	endproperty
	a_timer_gated: assert property (p_timer_gated) else $error("gated timer wrong"); // RULE_06

	property p_drive_gated;
		@(posedge clk_in) disable iff (!rstn_in)
		(instr_op_in == OP_DRIVE && is_r && !gate) |=> !relay_out[$past(ridx)];
	endproperty
	a_drive_gated: assert property (p_drive_gated) else $error("gated coil on"); // RULE_08

	property p_load_rise;
		@(posedge clk_in) disable iff (!rstn_in)
		(instr_op_in == OP_LOAD_RISE) |=> acc == ($past(opnd) && !$past(edge_hist[pc]));
	endproperty
	a_load_rise: assert property (p_load_rise) else $error("rising load wrong"); // RULE_12

	property p_scan_wrap;
		@(posedge clk_in) disable iff (!rstn_in)
		(instr_op_in == OP_PROG_END) |=> pc_out == '0 ##1 pc_out == PC_W'(1);
	endproperty
	a_scan_wrap: assert property (p_scan_wrap) else $error("scan did not wrap"); // RULE_19

	property p_gate_off;
		@(posedge clk_in) disable iff (!rstn_in)
		(instr_op_in == OP_GATE_BEGIN && !acc) |=> !region_gate_out;
	endproperty
	a_gate_off: assert property (p_gate_off) else $error("region not closed"); // RULE_11

endmodule

/* sim/lcem_prog_rom.sv */
// ************************************************************
// user program memory seen by the scan engine
// ************************************************************
module lcem_prog_rom #(
	parameter int PC_W = 5
) (
	input wire logic [PC_W-1:0] addr_in,
	output logic [lcem_pkg::OP_W-1:0] op_out,
	output logic [lcem_pkg::ARG_W-1:0] arg_out,
	output logic [lcem_pkg::IMM_W-1:0] imm_out
);
	timeunit 1ns;
	timeprecision 1ns;
	import lcem_pkg::*;

	logic [OP_W+ARG_W+IMM_W-1:0] mem [2**PC_W];
	int fill;

	// combinational read, same cycle as the address
	assign {op_out, arg_out, imm_out} = mem[addr_in];

	// wipe to no-operation words and restart filling at address 0
	task automatic clear_prog;
		foreach (mem[i]) mem[i] = '0;
		fill = 0;
	endtask

	// append one instruction word
	task automatic put(input logic [OP_W-1:0] op, input logic [ARG_W-1:0] arg,
		input logic [IMM_W-1:0] imm);
		mem[fill] = {op, arg, imm};
		fill++;
	endtask

	// every stored program is closed by an end word
	task automatic end_prog;
		put(OP_PROG_END, 8'h00, VAL_ZERO);
	endtask
endmodule

/* sim/ladder_counter_edge_master_control_bench.sv */
`define check_eq(g, e) begin total_checks++; if ((g) !== (e)) begin miscompares++; \
	$display("wrong value at %0t: output mismatch", $time); end end

module ladder_counter_edge_master_control_bench;
	timeunit 1ns;
	timeprecision 1ns;
	import lcem_pkg::*;

	localparam int PW = 5;
	logic clk_in = 1'b0;
	logic rstn_in;
	logic [NUM_X-1:0] pins;
	logic [OP_W-1:0] op;
	logic [ARG_W-1:0] arg;
	logic [IMM_W-1:0] imm;
	logic [PW-1:0] pc;
	logic [NUM_R-1:0] relay_out;
	logic [NUM_C-1:0] cnt_contact_out;
	logic [NUM_T-1:0] tmr_contact_out;
	logic region_gate_out;
	logic apply_fire_out;
	logic scan_done_out;
	int miscompares = 0;
	int total_checks = 0;
	logic [31:0] lfsr = 32'h7004;
	logic prog2 = 1'b0;
	logic prev0;
	logic ccoil;
	logic r1;
	int cnt;
	int tv;

	// ************************************************************
	// clock, design and program memory
	// ************************************************************
	always #50 clk_in = ~clk_in;

	lcem_engine #(.PC_W(PW)) lcem_engine_inst (.clk_in(clk_in), .rstn_in(rstn_in),
		.contact_pins_in(pins), .instr_op_in(op), .instr_arg_in(arg), .instr_imm_in(imm),
		.pc_out(pc), .relay_out(relay_out), .cnt_contact_out(cnt_contact_out),
		.tmr_contact_out(tmr_contact_out), .region_gate_out(region_gate_out),
		.apply_fire_out(apply_fire_out), .scan_done_out(scan_done_out));

	lcem_prog_rom #(.PC_W(PW)) lcem_prog_rom_inst (.addr_in(pc), .op_out(op), .arg_out(arg),
		.imm_out(imm));

	// ************************************************************
	// expectation helpers
	// ************************************************************
	function automatic logic [31:0] lfsr_next(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	// six edge results in relay order: rise, fall, and/or with X1
	function automatic logic [5:0] edge_exp(input logic x0, input logic x1, input logic p0);
		logic r;
		logic f;
		r = x0 & ~p0;
		f = ~x0 & p0;
		return {x1 | f, x1 | r, x1 & f, x1 & r, f, r};
	endfunction

	task automatic put(input logic [OP_W-1:0] o, input logic [ARG_W-1:0] a,
		input logic [IMM_W-1:0] i = VAL_ZERO);
		lcem_prog_rom_inst.put(o, a, i);
	endtask

	// three idle words first so new pins have crossed the synchroniser
	task automatic load_edges;
		logic [OP_W-1:0] ops [4];
		ops = '{OP_SERIES_RISE, OP_SERIES_FALL, OP_PAR_RISE, OP_PAR_FALL};
		lcem_prog_rom_inst.clear_prog();
		repeat (3) put(OP_NOP, 8'h00);
		put(OP_LOAD_RISE, 8'h00);
		put(OP_DRIVE, 8'h20);
		put(OP_LOAD_FALL, 8'h00);
		put(OP_DRIVE, 8'h21);
		for (int k = 0; k < 4; k++)
		begin
			put(OP_LOAD, 8'h01);
			put(ops[k], 8'h00);
			put(OP_DRIVE, 8'h22 + 8'(k));
		end
		// plain series and parallel of X0 with X1 into relays 6 and 7
		put(OP_LOAD, 8'h00);
		put(OP_SERIES, 8'h01);
		put(OP_DRIVE, 8'h26);
		put(OP_LOAD, 8'h00);
		put(OP_PARALLEL, 8'h01);
		put(OP_DRIVE, 8'h27);
		lcem_prog_rom_inst.end_prog();
	endtask

	// X1 gates level 0, X3 gates nested level 1, X0 pulses, X2 clears
	task automatic load_gates;
		lcem_prog_rom_inst.clear_prog();
		repeat (3) put(OP_NOP, 8'h00);
		put(OP_LOAD, 8'h01);
		put(OP_GATE_BEGIN, 8'h00);
		put(OP_LOAD, 8'h00);
		put(OP_COUNT_UP, 8'h60, 16'h0003);
		put(OP_LOAD, 8'h00);
		put(OP_DRIVE, 8'h20);
		put(OP_LOAD, 8'h00);
		put(OP_TIMER, 8'h70, 16'h0002);
		put(OP_LOAD, 8'h00);
		put(OP_LATCH, 8'h21);
		put(OP_LOAD, 8'h03);
		put(OP_GATE_BEGIN, 8'h01);
		put(OP_LOAD, 8'h00);
		put(OP_DRIVE, 8'h22);
		put(OP_APPLY, 8'h00);
		put(OP_GATE_END, 8'h01);
		put(OP_GATE_END, 8'h00);
		put(OP_LOAD, 8'h02);
		put(OP_CLEAR, 8'h60);
		put(OP_LOAD, 8'h02);
		put(OP_CLEAR, 8'h21);
		lcem_prog_rom_inst.end_prog();
	endtask

	// wait for the end of a scan, bounded; peek at the nested gate and the
	// application pulse on the way
	task automatic wait_done;
		int n;
		n = 0;
		do
		begin
			@(negedge clk_in);
			n++;
			if (prog2 && pc === 5'h11)
			begin
				`check_eq(region_gate_out, pins[1] & pins[3])
				`check_eq(apply_fire_out, pins[0] & pins[1] & pins[3])
			end
		end while (scan_done_out !== 1'b1 && n < 100);
		if (n >= 100)
		begin
			miscompares++;
			$display("wrong value at %0t: scan never ended", $time);
		end
		`check_eq(pc, 5'd0)
	endtask

	// new random pins at the edge that ends word 0 of the next scan; sixteen shifts so
	// that no pin simply repeats its neighbour from the scan before
	task automatic new_pins;
		logic [NUM_X-1:0] p;
		repeat (16) lfsr = lfsr_next(lfsr);
		p = lfsr[15:0];
		if (prog2)
		begin
			p[1] = lfsr[3] | lfsr[2];
			p[2] = (lfsr[8:6] == 3'h0);
			p[3] = lfsr[5];
		end
		@(posedge clk_in);
		pins <= p;
	endtask

	// counter, timer, latch and gated outputs after one scan
	task automatic model2;
		logic x0;
		logic x1;
		x0 = pins[0];
		x1 = pins[1];
		if (x1)
		begin
			if (x0 && !ccoil && cnt != 3)
				cnt++;
			ccoil = x0;
		end
		else
			ccoil = 1'b0;
		tv = (x1 && x0) ? ((tv < 2) ? tv + 1 : 2) : 0;
		if (x1 && x0)
			r1 = 1'b1;
		if (pins[2])
		begin
			cnt = 0;
			ccoil = 1'b0;
			r1 = 1'b0;
		end
		`check_eq(relay_out[0], x1 & x0)
		`check_eq(relay_out[1], r1)
		`check_eq(relay_out[2], x1 & pins[3] & x0)
		`check_eq(cnt_contact_out[0], cnt == 3)
		`check_eq(tmr_contact_out[0], x1 & x0 & (tv >= 2))
		`check_eq(region_gate_out, 1'b1)
	endtask

	task automatic summarize;
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// ************************************************************
	// main sequence and watchdog
	// ************************************************************
	initial
	begin
		#2000000;
		miscompares++;
		$display("wrong value at %0t: run hung", $time);
		summarize();
	end

	initial
	begin
		rstn_in = 1'b0;
		pins = 16'h0001;
		load_edges();
		repeat (5) @(posedge clk_in);
		`check_eq(cnt_contact_out, 8'hFF)
		rstn_in <= 1'b1;
		prev0 = 1'b0;
		repeat (40)
		begin
			wait_done();
			`check_eq(relay_out[5:0], edge_exp(pins[0], pins[1], prev0))
			`check_eq(relay_out[7:6], {pins[0] | pins[1], pins[0] & pins[1]})
			prev0 = pins[0];
			new_pins();
		end
		rstn_in <= 1'b0;
		// swap the program only once the engine is held in reset
		repeat (5) @(posedge clk_in);
		load_gates();
		cnt = 0;
		ccoil = 1'b0;
		tv = 0;
		r1 = 1'b0;
		prog2 = 1'b1;
		rstn_in <= 1'b1;
		repeat (150)
		begin
			wait_done();
			model2();
			new_pins();
		end
		summarize();
	end
endmodule
